// ===== hdl/gpio_port_override_regs.sv
/*
 * Ports A, B and C register set, global pull-up disable and port g
 * override logic for the timer oscillator and external memory strobes.
 * Assumes a single system clock, synchronous reset, an I/O bus with
 * io and data-space access, and pin pads outside that resolve drive.
 */
// Summary of operation
// - legacy mode keeps port g pins on alternate functions, never plain gpio
// - timer clock select frees g bit 4: pull-up, drive, input off
// - timer clock select frees g bit 3 likewise, as oscillator output
// - memory enable makes g bit 2 an output carrying the latch strobe
// - memory enable makes g bit 1 an output carrying the read strobe
// - memory enable makes g bit 0 an output carrying the write strobe
// - global pull-up disable bit turns off every port pull-up
// - registers answer at io offsets and at offset plus 0x20 in data space
// - control register at io 0x20, data 0x40, one pull-up disable bit
// - output latch registers: eight read/write bits, reset zero
// - direction registers: eight read/write bits, reset zero, pins input
// - pin sense registers read-only, following the pin levels
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_consts.svh"

module gpio_port_override_regs
#(
    parameter int G_PINS = 5
)
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    // register bus
    input  wire gpio_port_pkg::bus_addr_t  bus_addr,
    input  wire logic                      bus_io_space,
    input  wire logic                      bus_wr,
    input  wire logic                      bus_rd,
    input  wire gpio_port_pkg::port_byte_t bus_wdata,
    output gpio_port_pkg::port_byte_t      bus_rdata,
    output logic                           bus_rd_valid,
    // ports a to c pins
    input  wire gpio_port_pkg::port_byte_t port_a_in,
    input  wire gpio_port_pkg::port_byte_t port_b_in,
    input  wire gpio_port_pkg::port_byte_t port_c_in,
    output gpio_port_pkg::port_byte_t      port_a_out,
    output gpio_port_pkg::port_byte_t      port_b_out,
    output gpio_port_pkg::port_byte_t      port_c_out,
    output gpio_port_pkg::port_byte_t      port_a_oe_n,
    output gpio_port_pkg::port_byte_t      port_b_oe_n,
    output gpio_port_pkg::port_byte_t      port_c_oe_n,
    output gpio_port_pkg::port_byte_t      port_a_pullup,
    output gpio_port_pkg::port_byte_t      port_b_pullup,
    output gpio_port_pkg::port_byte_t      port_c_pullup,
    // port g controls
    input  wire logic                      compat_mode,
    input  wire logic                      async_timer_clock_select,
    input  wire logic                      ext_mem_enable,
    input  wire logic                      ale_strobe,
    input  wire logic                      rd_strobe,
    input  wire logic                      wr_strobe,
    input  wire logic [4:0]                port_g_latch,
    input  wire logic [4:0]                port_g_dir,
    // port g pins
    output logic [4:0]                     port_g_out,
    output logic [4:0]                     port_g_oe_n,
    output logic [4:0]                     port_g_pullup,
    output logic [4:0]                     port_g_din_en,
    output logic                           timer_osc_path
);

    import gpio_port_pkg::*;

    typedef struct packed {
        port_byte_t  latch_a;
        port_byte_t  latch_b;
        port_byte_t  latch_c;
        port_byte_t  dir_a;
        port_byte_t  dir_b;
        port_byte_t  dir_c;
        logic        pu_off;
        logic [23:0] sync1;
        logic [23:0] sync2;
        logic [23:0] sync3;
        logic [23:0] sense;
        port_byte_t  rdata;
        logic        rd_valid;
        logic [23:0] out;
        logic [23:0] oe_n;
        logic [23:0] pu_en;
        logic [4:0]  g_out;
        logic [4:0]  g_oe_n;
        logic [4:0]  g_pullup;
        logic [4:0]  g_din_en;
        logic        osc_path;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    if (G_PINS != 5)
    begin : g_check
        $error("port g override logic serves exactly five pins");
    end

    // io offset or data-space alias to register select
    function automatic reg_sel_t decode_sel(input bus_addr_t addr, input logic io);
        logic      hit;
        bus_addr_t ofs;
        hit = io ? (addr <= `GP_IO_LAST)
                 : (addr >= `GP_DS_DISP && addr <= `GP_DS_LAST);
        ofs = io ? addr : 16'(addr - `GP_DS_DISP);
        decode_sel = SEL_NONE;
        if (hit)
        begin
            case (ofs[5:0])
                `GP_OFS_A_LATCH: decode_sel = SEL_A_LATCH;
                `GP_OFS_A_DIR:   decode_sel = SEL_A_DIR;
                `GP_OFS_A_SENSE: decode_sel = SEL_A_SENSE;
                `GP_OFS_B_LATCH: decode_sel = SEL_B_LATCH;
                `GP_OFS_B_DIR:   decode_sel = SEL_B_DIR;
                `GP_OFS_B_SENSE: decode_sel = SEL_B_SENSE;
                `GP_OFS_C_LATCH: decode_sel = SEL_C_LATCH;
                `GP_OFS_C_DIR:   decode_sel = SEL_C_DIR;
                `GP_OFS_C_SENSE: decode_sel = SEL_C_SENSE;
                `GP_OFS_SFR:     decode_sel = SEL_SFR;
                default:         decode_sel = SEL_NONE;
            endcase
        end
    endfunction

    // pull-up on input pins whose latch is high
    function automatic port_byte_t pullup_of(input port_byte_t dir,
                                             input port_byte_t latch,
                                             input logic       dis);
        pullup_of = ~dir & latch & {8{~dis}};
    endfunction

    reg_sel_t   sel;
    logic       osc_ovr;
    logic       mem_ovr;
    logic [4:0] pue;
    logic [4:0] puv;
    logic [4:0] dde;
    logic [4:0] ddv;
    logic [4:0] pve;
    logic [4:0] pvv;
    logic [4:0] diee;
    logic [4:0] diev;
    logic [4:0] g_pull_c;
    logic [4:0] g_drv_c;
    logic [4:0] g_val_c;
    logic [4:0] g_die_c;

    assign sel = decode_sel(bus_addr, bus_io_space);

    // legacy mode pins both alternate groups on
    assign osc_ovr = async_timer_clock_select | compat_mode;
    assign mem_ovr = ext_mem_enable | compat_mode;

    // oscillator pins: pull-up, drive and input off, output value left to the latch
    assign pue[4:3]  = {2{osc_ovr}};
    assign puv[4:3]  = 2'b00;
    assign dde[4:3]  = {2{osc_ovr}};
    assign ddv[4:3]  = 2'b00;
    assign pve[4:3]  = 2'b00;
    assign pvv[4:3]  = 2'b00;
    assign diee[4:3] = {2{osc_ovr}};
    assign diev[4:3] = 2'b00;

    // memory strobe pins: forced outputs carrying the strobes
    assign pue[2:0]  = {3{mem_ovr}};
    assign puv[2:0]  = 3'h0;
    assign dde[2:0]  = {3{mem_ovr}};
    assign ddv[2:0]  = 3'h7;
    assign pve[2:0]  = {3{mem_ovr}};
    assign pvv[2:0]  = {ale_strobe, rd_strobe, wr_strobe};
    assign diee[2:0] = 3'h0;
    assign diev[2:0] = 3'h0;

    for (genvar i = 0; i < 5; i++)
    begin : g_slice
        pin_override_slice pin_override_slice_i
        (
            .reg_latch                 (port_g_latch[i]),
            .reg_dir                   (port_g_dir[i]),
            .pullup_global_disable     (s_r.pu_off),
            .pullup_override_en        (pue[i]),
            .pullup_override_val       (puv[i]),
            .direction_override_en     (dde[i]),
            .direction_override_val    (ddv[i]),
            .outval_override_en        (pve[i]),
            .outval_override_val       (pvv[i]),
            .input_enable_override_en  (diee[i]),
            .input_enable_override_val (diev[i]),
            .pullup_en                 (g_pull_c[i]),
            .drive                     (g_drv_c[i]),
            .out_val                   (g_val_c[i]),
            .din_en                    (g_die_c[i])
        );
    end

    always_comb
    begin
        s_nxt = s_r;
        // register writes
        if (bus_wr)
        begin
            case (sel)
                SEL_A_LATCH: s_nxt.latch_a = bus_wdata;
                SEL_B_LATCH: s_nxt.latch_b = bus_wdata;
                SEL_C_LATCH: s_nxt.latch_c = bus_wdata;
                SEL_A_DIR:   s_nxt.dir_a = bus_wdata;
                SEL_B_DIR:   s_nxt.dir_b = bus_wdata;
                SEL_C_DIR:   s_nxt.dir_c = bus_wdata;
                SEL_SFR:     s_nxt.pu_off = bus_wdata[`GP_PU_DIS_BIT];
                default:     s_nxt.pu_off = s_r.pu_off; // sense is read-only
            endcase
        end
        // register reads, unmapped reads give zero
        s_nxt.rd_valid = bus_rd;
        if (bus_rd)
        begin
            case (sel)
                SEL_A_LATCH: s_nxt.rdata = s_r.latch_a;
                SEL_B_LATCH: s_nxt.rdata = s_r.latch_b;
                SEL_C_LATCH: s_nxt.rdata = s_r.latch_c;
                SEL_A_DIR:   s_nxt.rdata = s_r.dir_a;
                SEL_B_DIR:   s_nxt.rdata = s_r.dir_b;
                SEL_C_DIR:   s_nxt.rdata = s_r.dir_c;
                SEL_A_SENSE: s_nxt.rdata = s_r.sense[7:0];
                SEL_B_SENSE: s_nxt.rdata = s_r.sense[15:8];
                SEL_C_SENSE: s_nxt.rdata = s_r.sense[23:16];
                SEL_SFR:
                begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rdata[`GP_PU_DIS_BIT] = s_r.pu_off;
                end
                default:     s_nxt.rdata = `GP_UNMAPPED_RD;
            endcase
        end
        // pin sense: three stages, update once stages two and three agree
        s_nxt.sync1 = {port_c_in, port_b_in, port_a_in};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        for (int i = 0; i < 24; i++)
        begin
            if (s_r.sync2[i] == s_r.sync3[i])
            begin
                s_nxt.sense[i] = s_r.sync3[i];
            end
        end
        // ports a to c pads
        s_nxt.out    = {s_r.latch_c, s_r.latch_b, s_r.latch_a};
        s_nxt.oe_n   = ~{s_r.dir_c, s_r.dir_b, s_r.dir_a};
        s_nxt.pu_en = {pullup_of(s_r.dir_c, s_r.latch_c, s_r.pu_off),
                       pullup_of(s_r.dir_b, s_r.latch_b, s_r.pu_off),
                       pullup_of(s_r.dir_a, s_r.latch_a, s_r.pu_off)};
        // port g pads through the override slices
        s_nxt.g_out    = g_val_c;
        s_nxt.g_oe_n   = ~g_drv_c;
        s_nxt.g_pullup = g_pull_c;
        s_nxt.g_din_en = g_die_c;
        s_nxt.osc_path = osc_ovr;
        if (rst)
        begin
            s_nxt          = '0;
            s_nxt.latch_a  = `GP_LATCH_RST;
            s_nxt.latch_b  = `GP_LATCH_RST;
            s_nxt.latch_c  = `GP_LATCH_RST;
            s_nxt.dir_a    = `GP_DIR_RST;
            s_nxt.dir_b    = `GP_DIR_RST;
            s_nxt.dir_c    = `GP_DIR_RST;
            s_nxt.pu_off   = `GP_SFR_RST;
            s_nxt.sense    = {3{`GP_SENSE_RST}};
            s_nxt.oe_n     = '1;
            s_nxt.g_oe_n   = '1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        s_r <= s_nxt;
    end

    assign bus_rdata     = s_r.rdata;
    assign bus_rd_valid  = s_r.rd_valid;
    assign port_a_out    = s_r.out[7:0];
    assign port_b_out    = s_r.out[15:8];
    assign port_c_out    = s_r.out[23:16];
    assign port_a_oe_n   = s_r.oe_n[7:0];
    assign port_b_oe_n   = s_r.oe_n[15:8];
    assign port_c_oe_n   = s_r.oe_n[23:16];
    assign port_a_pullup = s_r.pu_en[7:0];
    assign port_b_pullup = s_r.pu_en[15:8];
    assign port_c_pullup = s_r.pu_en[23:16];
    assign port_g_out    = s_r.g_out;
    assign port_g_oe_n   = s_r.g_oe_n;
    assign port_g_pullup = s_r.g_pullup;
    assign port_g_din_en = s_r.g_din_en;
    assign timer_osc_path = s_r.osc_path;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_io_wr(logic [15:0] a);
        bus_wr && bus_io_space && bus_addr == a;
    endsequence

    sequence s_ds_wr(logic [15:0] a);
        bus_wr && !bus_io_space && bus_addr == a;
    endsequence

    a_legacy_g_alt: assert property (
        !rst && compat_mode |=> (s_r.g_oe_n[2:0] == 3'h0 && s_r.g_din_en[4:3] == 2'b00))
        else $error("legacy mode left port g usable as gpio");

    a_osc_in_off: assert property (
        async_timer_clock_select |=>
            (!port_g_pullup[4] && port_g_oe_n[4] && !port_g_din_en[4] && timer_osc_path))
        else $error("oscillator input pin not released");

    a_osc_out_off: assert property (
        async_timer_clock_select |=>
            (!port_g_pullup[3] && port_g_oe_n[3] && !port_g_din_en[3]))
        else $error("oscillator output pin not released");

    a_ale_drive: assert property (
        ext_mem_enable |=>
            (!port_g_oe_n[2] && !port_g_pullup[2] && port_g_out[2] == $past(ale_strobe)))
        else $error("latch strobe pin not driven");

    a_rd_drive: assert property (
        ext_mem_enable |=>
            (!port_g_oe_n[1] && !port_g_pullup[1] && port_g_out[1] == $past(rd_strobe)))
        else $error("read strobe pin not driven");

    a_wr_drive: assert property (
        ext_mem_enable |=>
            (!port_g_oe_n[0] && !port_g_pullup[0] && port_g_out[0] == $past(wr_strobe)))
        else $error("write strobe pin not driven");

    a_global_pu_off: assert property (
        !rst && s_r.pu_off |=> (s_r.pu_en == 24'h0 && port_g_pullup == 5'h00))
        else $error("pull-up active under global disable");

    a_sfr_io_alias: assert property (
        s_io_wr(16'h0020) |=> s_r.pu_off == $past(bus_wdata[`GP_PU_DIS_BIT]))
        else $error("control register io write lost");

    a_sfr_ds_alias: assert property (
        s_ds_wr(16'h0040) |=> s_r.pu_off == $past(bus_wdata[`GP_PU_DIS_BIT]))
        else $error("control register data-space write lost");

    a_latch_write: assert property (
        s_io_wr(16'h001B) ##1 !rst |=> port_a_out == $past(bus_wdata, 2))
        else $error("port a latch write not on pins");

    a_dir_write: assert property (
        s_ds_wr(16'h0037) ##1 !rst |=> port_b_oe_n == ~$past(bus_wdata, 2))
        else $error("port b direction write not on pins");

    a_sense_read: assert property (
        (bus_rd && bus_io_space && bus_addr == 16'h0019) |=>
            (bus_rd_valid && bus_rdata == $past(s_r.sense[7:0])))
        else $error("port a sense read wrong");

    a_override_off: assert property (
        (!rst && !ext_mem_enable && !compat_mode) |=>
            (port_g_out[2:0] == $past(port_g_latch[2:0])
             && port_g_oe_n[2:0] == ~$past(port_g_dir[2:0])))
        else $error("register path not selected without override");

endmodule

`default_nettype wire

// ===== hdl/pin_override_slice.sv
/*
 * One pin of override logic: each class picks the override value
 * when its enable is set, else the register-derived value; input enable instead defaults to on.
 * Assumes all inputs on the system clock; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_override_slice
(
    // register side
    input  wire logic reg_latch,
    input  wire logic reg_dir,
    input  wire logic pullup_global_disable,
    // override controls
    input  wire logic pullup_override_en,
    input  wire logic pullup_override_val,
    input  wire logic direction_override_en,
    input  wire logic direction_override_val,
    input  wire logic outval_override_en,
    input  wire logic outval_override_val,
    input  wire logic input_enable_override_en,
    input  wire logic input_enable_override_val,
    // pin side
    output logic      pullup_en,
    output logic      drive,
    output logic      out_val,
    output logic      din_en
);

    // register-derived pull-up: input with latch high, no global disable
    assign pullup_en = pullup_override_en ? pullup_override_val
                                          : (~reg_dir & reg_latch & ~pullup_global_disable);
    assign drive   = direction_override_en ? direction_override_val : reg_dir;
    assign out_val = outval_override_en ? outval_override_val : reg_latch;
    assign din_en  = input_enable_override_en ? input_enable_override_val : 1'b1;

endmodule

`default_nettype wire

// ===== inc/gpio_port_consts.svh
/*
 * Register offsets, field positions, reset values and address windows
 * of the general-purpose port block.
 * Assumes an 8-bit I/O bus with a 16-bit data-space address.
 */
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// i/o offsets
`define GP_OFS_C_SENSE   6'h13
`define GP_OFS_C_DIR     6'h14
`define GP_OFS_C_LATCH   6'h15
`define GP_OFS_B_SENSE   6'h16
`define GP_OFS_B_DIR     6'h17
`define GP_OFS_B_LATCH   6'h18
`define GP_OFS_A_SENSE   6'h19
`define GP_OFS_A_DIR     6'h1A
`define GP_OFS_A_LATCH   6'h1B
`define GP_OFS_SFR       6'h20

// address windows
`define GP_IO_LAST       16'h003F
`define GP_DS_DISP       16'h0020
`define GP_DS_LAST       16'h005F

// fields and reset values
`define GP_PU_DIS_BIT    2
`define GP_LATCH_RST     8'h00
`define GP_DIR_RST       8'h00
`define GP_SENSE_RST     8'h00
`define GP_SFR_RST       1'b0
`define GP_UNMAPPED_RD   8'h00

// port g pin positions
`define GP_G_OSC_IN      4
`define GP_G_OSC_OUT     3
`define GP_G_ALE         2
`define GP_G_RD          1
`define GP_G_WR          0

`endif

// ===== inc/gpio_port_pkg.sv
/*
 * Types shared by the general-purpose port block.
 * Assumes the constants header is compiled alongside.
 */
package gpio_port_pkg;

    typedef logic [7:0]  port_byte_t;
    typedef logic [15:0] bus_addr_t;

    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_A_LATCH,
        SEL_A_DIR,
        SEL_A_SENSE,
        SEL_B_LATCH,
        SEL_B_DIR,
        SEL_B_SENSE,
        SEL_C_LATCH,
        SEL_C_DIR,
        SEL_C_SENSE,
        SEL_SFR
    } reg_sel_t;

endpackage

// ===== verif/gpio_pin_partner.sv
/*
 * Pad model for ports a to c: device drive, outside driver, pull-up.
 * Assumes pad controls packed as {c, b, a} from the port block.
 */
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_partner
(
    // pad controls
    input  wire logic [23:0] pin_out,
    input  wire logic [23:0] pin_oe_n,
    input  wire logic [23:0] pin_pullup,
    // outside driver
    input  wire logic [23:0] ext_level,
    input  wire logic [23:0] ext_drive,
    // pin levels
    output logic [23:0]      pin_level
);
    always_comb
    begin
        for (int i = 0; i < 24; i++)
        begin
            if (!pin_oe_n[i])
                pin_level[i] = pin_out[i];
            else if (ext_drive[i])
                pin_level[i] = ext_level[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = ~ext_level[i];  // floating pin, no kept value
        end
    end
endmodule

`default_nettype wire

// ===== verif/gpio_port_override_regs_tb_top.sv
/*
 * Self-checking bench for the port register set and port g overrides.
 * Assumes the design package and the pad model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module gpio_port_override_regs_tb_top;
    import gpio_port_pkg::*;

    logic       ref_clk, rst, bus_io_space, bus_wr, bus_rd, bus_rd_valid;
    bus_addr_t  bus_addr;
    port_byte_t bus_wdata, bus_rdata, a_out, b_out, c_out;
    port_byte_t a_oe_n, b_oe_n, c_oe_n, a_pu, b_pu, c_pu;
    logic       compat_mode, async_timer_clock_select, ext_mem_enable;
    logic       ale_strobe, rd_strobe, wr_strobe, timer_osc_path;
    logic [4:0] g_latch, g_dir, g_out, g_oe_n, g_pu, g_din;
    logic [23:0] ext_level, ext_drive, pin_level;
    int         err_count, total_checks;

    gpio_port_override_regs gpio_port_override_regs_i (
        .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_io_space(bus_io_space),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rd_valid(bus_rd_valid), .port_a_in(pin_level[7:0]),
        .port_b_in(pin_level[15:8]), .port_c_in(pin_level[23:16]),
        .port_a_out(a_out), .port_b_out(b_out), .port_c_out(c_out),
        .port_a_oe_n(a_oe_n), .port_b_oe_n(b_oe_n), .port_c_oe_n(c_oe_n),
        .port_a_pullup(a_pu), .port_b_pullup(b_pu), .port_c_pullup(c_pu),
        .compat_mode(compat_mode), .async_timer_clock_select(async_timer_clock_select),
        .ext_mem_enable(ext_mem_enable), .ale_strobe(ale_strobe), .rd_strobe(rd_strobe),
        .wr_strobe(wr_strobe), .port_g_latch(g_latch), .port_g_dir(g_dir),
        .port_g_out(g_out), .port_g_oe_n(g_oe_n), .port_g_pullup(g_pu),
        .port_g_din_en(g_din), .timer_osc_path(timer_osc_path));

    gpio_pin_partner gpio_pin_partner_i (
        .pin_out({c_out, b_out, a_out}), .pin_oe_n({c_oe_n, b_oe_n, a_oe_n}),
        .pin_pullup({c_pu, b_pu, a_pu}), .ext_level(ext_level),
        .ext_drive(ext_drive), .pin_level(pin_level));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input port_byte_t exp, input port_byte_t got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic bus_write(input bus_addr_t a, input logic io, input port_byte_t d);
        @(posedge ref_clk);
        bus_addr     <= a;
        bus_io_space <= io;
        bus_wdata    <= d;
        bus_wr       <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input bus_addr_t a, input logic io,
                          input port_byte_t exp);
        int n;
        @(posedge ref_clk);
        bus_addr     <= a;
        bus_io_space <= io;
        bus_rd       <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        n = 0;
        while (bus_rd_valid !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (bus_rd_valid !== 1'b1)
        begin
            err_count++;
            $display("unexpected %s read valid: expected 1 seen 0", name);
            stop_test();
        end
        chk(name, exp, bus_rdata);
    endtask

    task automatic gset(input logic cm, input logic as, input logic em);
        @(posedge ref_clk);
        compat_mode              <= cm;
        async_timer_clock_select <= as;
        ext_mem_enable           <= em;
        settle(2);
    endtask

    task automatic gchk(input port_byte_t o, input port_byte_t oe, input port_byte_t pu,
                        input port_byte_t di, input logic tm);
        chk("g out", o, {3'h0, g_out});
        chk("g oe_n", oe, {3'h0, g_oe_n});
        chk("g pullup", pu, {3'h0, g_pu});
        chk("g din_en", di, {3'h0, g_din});
        chk("osc path", {7'h00, tm}, {7'h00, timer_osc_path});
    endtask

    task automatic t_reset();
        rd_chk("a latch", 16'h001B, 1'b1, 8'h00);
        rd_chk("b dir", 16'h0017, 1'b1, 8'h00);
        rd_chk("ctrl", 16'h0040, 1'b0, 8'h00);
        chk("a oe_n", 8'hFF, a_oe_n);
        chk("c pullup", 8'h00, c_pu);
    endtask

    task automatic t_regs();
        bus_write(16'h001B, 1'b1, 8'h5A);
        bus_write(16'h003A, 1'b0, 8'hC3);
        bus_write(16'h0038, 1'b0, 8'h96);
        bus_write(16'h0017, 1'b1, 8'hFF);
        bus_write(16'h0015, 1'b1, 8'hF0);
        bus_write(16'h0034, 1'b0, 8'h0F);
        settle(2);
        chk("a out", 8'h5A, a_out);
        chk("a oe_n", 8'h3C, a_oe_n);
        chk("b oe_n", 8'h00, b_oe_n);
        chk("c out", 8'hF0, c_out);
        chk("a pullup", 8'h18, a_pu);
        chk("c pullup", 8'hF0, c_pu);
        chk("b out", 8'h96, b_out);
        chk("b pullup", 8'h00, b_pu);
        chk("c oe_n", 8'hF0, c_oe_n);
        rd_chk("a latch", 16'h003B, 1'b0, 8'h5A);
        rd_chk("a dir", 16'h001A, 1'b1, 8'hC3);
        rd_chk("b latch", 16'h0018, 1'b1, 8'h96);
        rd_chk("c dir", 16'h0014, 1'b1, 8'h0F);
        rd_chk("c latch", 16'h0035, 1'b0, 8'hF0);
    endtask

    task automatic t_sense();
        @(posedge ref_clk);
        ext_drive <= 24'h0000FF;
        ext_level <= 24'h000024;
        settle(6);
        rd_chk("a sense", 16'h0019, 1'b1, 8'h66);
        rd_chk("b sense", 16'h0036, 1'b0, 8'h96);
        rd_chk("c sense", 16'h0013, 1'b1, 8'hF0);
        bus_write(16'h0019, 1'b1, 8'hFF);
        ext_level <= 24'h000018;
        settle(6);
        rd_chk("a sense", 16'h0039, 1'b0, 8'h5A);
        rd_chk("io unmapped", 16'h003E, 1'b1, 8'h00);
        rd_chk("io above", 16'h0040, 1'b1, 8'h00);
        rd_chk("extended", 16'h0060, 1'b0, 8'h00);
    endtask

    task automatic t_pud();
        bus_write(16'h0040, 1'b0, 8'hFF);
        settle(3);
        rd_chk("ctrl", 16'h0020, 1'b1, 8'h04);
        chk("a pullup", 8'h00, a_pu);
        chk("c pullup", 8'h00, c_pu);
        chk("g pullup", 8'h00, {3'h0, g_pu});
        bus_write(16'h0020, 1'b1, 8'h00);
        settle(3);
        chk("c pullup", 8'hF0, c_pu);
    endtask

    task automatic t_port_g();
        gset(1'b0, 1'b0, 1'b0);
        gchk(8'h15, 8'h13, 8'h11, 8'h1F, 1'b0);
        gset(1'b0, 1'b0, 1'b1);
        gchk(8'h12, 8'h10, 8'h10, 8'h1F, 1'b0);
        gset(1'b0, 1'b1, 1'b0);
        gchk(8'h15, 8'h1B, 8'h01, 8'h07, 1'b1);
        @(posedge ref_clk);
        ale_strobe <= 1'b1;
        rd_strobe  <= 1'b0;
        gset(1'b1, 1'b0, 1'b0);
        gchk(8'h14, 8'h18, 8'h00, 8'h07, 1'b1);
        gset(1'b0, 1'b0, 1'b0);
        gchk(8'h15, 8'h13, 8'h11, 8'h1F, 1'b0);
    endtask

    initial
    begin
        err_count = 0;
        total_checks = 0;
        rst = 1'b1;
        bus_addr = 16'h0000;
        bus_io_space = 1'b1;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
        compat_mode = 1'b0;
        async_timer_clock_select = 1'b0;
        ext_mem_enable = 1'b0;
        ale_strobe = 1'b0;
        rd_strobe = 1'b1;
        wr_strobe = 1'b0;
        g_latch = 5'h15;
        g_dir = 5'h0C;
        ext_level = 24'h000000;
        ext_drive = 24'hFFFFFF;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_sense();
        t_port_g();
        t_pud();
        stop_test();
    end
endmodule

`default_nettype wire
